// ===== core/asram_ctrl.sv
`default_nettype none
module asram_ctrl (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire asram_pkg::asram_req_type i_req,
    output logic o_req_ready,
    output logic o_rdata_valid,
    output logic [asram_pkg::DATA_W-1:0] o_rdata,
    output asram_pkg::asram_pins_type o_pins,
    input wire logic [asram_pkg::DATA_W-1:0] i_byte_bus,
    output logic [asram_pkg::DATA_W-1:0] o_byte_bus,
    output logic o_byte_bus_oe
);
    // ********************************
    // State
    // ********************************
    typedef enum logic [2:0] {ST_IDLE, ST_RSETUP, ST_READ, ST_RTURN, ST_WSETUP, ST_WRITE, ST_WEND} asram_state_type;
    asram_state_type state_r;
    logic load;
    logic [asram_pkg::CNT_W-1:0] load_cnt;
    logic done;
    logic [asram_pkg::DATA_W-1:0] bus_s1_r;
    logic [asram_pkg::DATA_W-1:0] bus_s2_r;

    asram_delay #(.W(asram_pkg::CNT_W)) u_delay (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_load(load),
        .i_count(load_cnt),
        .o_done(done)
    );

    // Pins from the memory pass two flops before use
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            bus_s1_r <= '0;
            bus_s2_r <= '0;
        end else begin
            bus_s1_r <= i_byte_bus;
            bus_s2_r <= bus_s1_r;
        end
    end

    always_comb begin
        load = 1'b0;
        load_cnt = '0;
        unique case (state_r)
            ST_IDLE: begin
                if (i_req_valid) begin
                    load = 1'b1;
                    load_cnt = 4'h1;
                end
            end
            // Two extra cycles cover the input synchroniser
            ST_RSETUP: begin
                load = 1'b1;
                load_cnt = 4'(asram_pkg::READ_CYC + 2);
            end
            ST_READ: begin
                if (done) begin
                    load = 1'b1;
                    load_cnt = 4'(asram_pkg::TURN_CYC);
                end
            end
            ST_WSETUP: begin
                load = 1'b1;
                load_cnt = 4'(asram_pkg::STORE_CYC > asram_pkg::BYTE_CYC ?
                    asram_pkg::STORE_CYC : asram_pkg::BYTE_CYC);
            end
            default: begin
            end
        endcase
    end

    // ********************************
    // Sequencer
    // ********************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (i_req_valid) begin
                        state_r <= i_req.write ? ST_WSETUP : ST_RSETUP;
                    end
                end
                ST_RSETUP: begin
                    state_r <= ST_READ;
                end
                ST_READ: begin
                    if (done) begin
                        state_r <= ST_RTURN;
                    end
                end
                ST_RTURN: begin
                    if (done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_WSETUP: begin
                    state_r <= ST_WRITE;
                end
                ST_WRITE: begin
                    if (done) begin
                        state_r <= ST_WEND;
                    end
                end
                ST_WEND: begin
                    state_r <= ST_IDLE;
                end
                // Spare code; back to idle, where the strobes keep whatever level they had
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // Pins
    // ********************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_pins.select_low_active_n <= 1'b1;
            o_pins.select_high_active <= 1'b0;
            o_pins.out_enable_n <= 1'b1;
            o_pins.write_enable_n <= 1'b1;
            o_pins.location_lines <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // Address settles a cycle before any select edge
                    if (i_req_valid) begin
                        o_pins.location_lines <= i_req.addr;
                    end
                end
                ST_RSETUP: begin
                    o_pins.select_low_active_n <= 1'b0;
                    o_pins.select_high_active <= 1'b1;
                    o_pins.out_enable_n <= 1'b0;
                    o_pins.write_enable_n <= 1'b1;
                end
                ST_READ: begin
                    if (done) begin
                        o_pins.select_low_active_n <= 1'b1;
                        o_pins.select_high_active <= 1'b0;
                        o_pins.out_enable_n <= 1'b1;
                    end
                end
                ST_WSETUP: begin
                    // Output enable stays high, so the memory never drives here
                    o_pins.out_enable_n <= 1'b1;
                    o_pins.select_low_active_n <= 1'b0;
                    o_pins.select_high_active <= 1'b1;
                    o_pins.write_enable_n <= 1'b0;
                end
                ST_WRITE: begin
                    if (done) begin
                        // All strobes end together; address and data stay put
                        o_pins.write_enable_n <= 1'b1;
                        o_pins.select_low_active_n <= 1'b1;
                        o_pins.select_high_active <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************
    // Data bus driver
    // ********************************
    // Driven from the select edge of a write to one cycle past its end
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_byte_bus <= '0;
            o_byte_bus_oe <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // Data settles with the address, before the bus is enabled
                    if (i_req_valid) begin
                        o_byte_bus <= i_req.wdata;
                    end
                end
                ST_RSETUP: begin
                    o_byte_bus_oe <= 1'b0;
                end
                ST_WSETUP: begin
                    o_byte_bus_oe <= 1'b1;
                end
                ST_WEND: begin
                    o_byte_bus_oe <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************
    // Host side
    // ********************************
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_req_ready <= 1'b0;
        end else begin
            o_req_ready <= (state_r == ST_IDLE) && !i_req_valid;
        end
    end

    // Read byte holds until the next read; valid is a one-cycle pulse
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_rdata_valid <= 1'b0;
            o_rdata <= '0;
        end else begin
            o_rdata_valid <= 1'b0;
            if (state_r == ST_READ && done) begin
                o_rdata <= bus_s2_r;
                o_rdata_valid <= 1'b1;
            end
        end
    end
endmodule // asram_ctrl
`default_nettype wire

// ===== include/asram_pkg.sv
`default_nettype none
package asram_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Fast grade figures
    localparam int ADDRESS_TO_VALID_DELAY_NS = 55;
    localparam int ADDRESS_CHANGE_HOLD_NS = 5;
    localparam int OUTPUT_ENABLE_TO_VALID_DELAY_NS = 20;
    localparam int ADDRESS_BEFORE_STORE_END_NS = 45;
    localparam int BYTE_BEFORE_STORE_END_NS = 45;
    localparam int WRITE_PULSE_NS = 45;
    localparam int OUTPUT_OFF_NS = 20;
    // Least times round up
    localparam int READ_CYC = (ADDRESS_TO_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_CYC = (ADDRESS_BEFORE_STORE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_CYC = (BYTE_BEFORE_STORE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asram_req_type;

    typedef struct packed {
        logic select_low_active_n;
        logic select_high_active;
        logic out_enable_n;
        logic write_enable_n;
        logic [ADDR_W-1:0] location_lines;
    } asram_pins_type;
endpackage
`default_nettype wire

// ===== core/asram_delay.sv
`default_nettype none
module asram_delay #(
    parameter int W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    logic [W-1:0] cnt_r;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
    // Count alone: the caller's load depends on done, so gating with load would loop
    assign o_done = (cnt_r == '0);
endmodule // asram_delay
`default_nettype wire

// ===== tb/asram_mem_model.sv
`default_nettype none
module asram_mem_model (
    input wire asram_pkg::asram_pins_type i_pins,
    input wire logic [7:0] i_bus,
    output logic [7:0] o_q,
    output logic o_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Device
    // ****
    logic [7:0] mem_r [0:131071];
    asram_pkg::asram_pins_type pins_d;
    wire logic sel = !i_pins.select_low_active_n && i_pins.select_high_active;
    wire logic store = sel && !i_pins.write_enable_n;
    // Byte is only trusted once the pins sat still a whole access time
    assign #50 pins_d = i_pins;
    assign o_oe = sel && !i_pins.out_enable_n && i_pins.write_enable_n;
    // Old byte lingers 5 ns after a pin change; 50 plus 5 makes the full access time
    assign #5 o_q = (pins_d === i_pins) ? mem_r[i_pins.location_lines] : ~mem_r[i_pins.location_lines];
    always @(negedge store) begin
        mem_r[i_pins.location_lines] = i_bus;
    end
endmodule // asram_mem_model
`default_nettype wire

// ===== tb/asram_ctrl_props.sv
`default_nettype none
module asram_ctrl_props (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire asram_pkg::asram_req_type i_req,
    input wire logic o_rdata_valid,
    input wire logic o_req_ready,
    input wire asram_pkg::asram_pins_type o_pins,
    input wire logic [7:0] o_byte_bus,
    input wire logic o_byte_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Pin timing
    // ****
    wire logic sel = !o_pins.select_low_active_n && o_pins.select_high_active;
    wire logic store = sel && !o_pins.write_enable_n;
    wire logic rd = sel && !o_pins.out_enable_n;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    sequence s_store_go; $rose(store); endsequence
    sequence s_read_go; $rose(rd); endsequence
    sequence s_read_take; i_req_valid && o_req_ready && !i_req.write; endsequence
    we_in_read_a: assert property (!o_pins.out_enable_n |-> o_pins.write_enable_n) else $error("we low in read");
    no_clash_a: assert property (o_byte_bus_oe |-> o_pins.out_enable_n) else $error("bus clash");
    addr_first_a: assert property ($rose(sel) |-> $stable(o_pins.location_lines)) else $error("addr late");
    store_addr_a: assert property ($past(store) |-> $stable(o_pins.location_lines)) else $error("addr moved");
    store_len_a: assert property (s_store_go |-> store [*5]) else $error("store short");
    byte_setup_a: assert property (store |-> o_byte_bus_oe) else $error("byte late");
    byte_hold_a: assert property ($past(store) |-> o_byte_bus_oe && $stable(o_byte_bus)) else $error("byte moved");
    read_len_a: assert property (s_read_go |-> rd [*6]) else $error("read short");
    answer_a: assert property (s_read_take |-> ##1 !o_rdata_valid [*8] ##[2:3] o_rdata_valid) else $error("answer");
endmodule // asram_ctrl_props
bind asram_ctrl asram_ctrl_props i_props (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_rdata_valid(o_rdata_valid), .o_req_ready(o_req_ready), .o_pins(o_pins),
    .o_byte_bus(o_byte_bus), .o_byte_bus_oe(o_byte_bus_oe));
`default_nettype wire

// ===== tb/asram_ctrl_tb.sv
`default_nettype none
module asram_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [16:0] a; logic [7:0] d;} asram_row_type;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_req_valid = 1'b0;
    asram_pkg::asram_req_type i_req = '0;
    logic o_req_ready, o_rdata_valid, o_byte_bus_oe, mem_oe;
    logic [7:0] o_rdata, o_byte_bus, mem_q, bus, bus_hold;
    asram_pkg::asram_pins_type o_pins;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    asram_row_type rows [8] = '{{1'b1, 17'h00000, 8'h5a}, {1'b1, 17'h1ffff, 8'ha5}, {1'b1, 17'h0aaaa, 8'h3c},
        {1'b0, 17'h00000, 8'h5a}, {1'b0, 17'h1ffff, 8'ha5}, {1'b0, 17'h0aaaa, 8'h3c},
        {1'b1, 17'h0aaaa, 8'hc3}, {1'b0, 17'h0aaaa, 8'hc3}};
    // ****
    // Harness
    // ****
    always #5 i_clk_sys = ~i_clk_sys;
    // A released bus keeps moving so a stale byte never reads as good
    assign bus = o_byte_bus_oe ? o_byte_bus : (mem_oe ? mem_q : ~bus_hold);
    always @(posedge i_clk_sys) begin
        bus_hold <= bus;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            wrap_up();
        end
    end
    asram_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .o_pins(o_pins),
        .i_byte_bus(bus), .o_byte_bus(o_byte_bus), .o_byte_bus_oe(o_byte_bus_oe));
    asram_mem_model i_mem (.i_pins(o_pins), .i_bus(bus), .o_q(mem_q), .o_oe(mem_oe));
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic s);
        chk8(nm, {7'h00, e}, {7'h00, s});
    endtask
    task automatic do_req(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 40) begin
            @(posedge i_clk_sys);
            #1 n++;
        end
        chk1("req_ready", 1'b1, o_req_ready);
        i_req = '{w, a, d};
        i_req_valid = 1'b1;
        @(posedge i_clk_sys);
        #1 i_req_valid = 1'b0;
        n = 0;
        while (!w && o_rdata_valid !== 1'b1 && n < 20) begin
            @(posedge i_clk_sys);
            #1 n++;
        end
        if (!w) chk1("rdata_valid", 1'b1, o_rdata_valid);
        if (!w) chk8("rdata", d, o_rdata);
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        foreach (rows[i]) do_req(rows[i].w, rows[i].a, rows[i].d);
        // Request while busy must be dropped
        do_req(1'b1, 17'h00123, 8'h81);
        @(posedge i_clk_sys);
        #1 i_req = '{1'b1, 17'h00123, 8'h7e};
        i_req_valid = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        #1 i_req_valid = 1'b0;
        do_req(1'b0, 17'h00123, 8'h81);
        // Reset in mid-store
        do_req(1'b1, 17'h00042, 8'h11);
        repeat (3) @(posedge i_clk_sys);
        #1 i_reset = 1'b1;
        #1 chk1("sel_n", 1'b1, o_pins.select_low_active_n);
        chk1("bus_oe", 1'b0, o_byte_bus_oe);
        chk1("we_n", 1'b1, o_pins.write_enable_n);
        chk1("sel_h", 1'b0, o_pins.select_high_active);
        chk1("oe_n", 1'b1, o_pins.out_enable_n);
        @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        do_req(1'b0, 17'h1ffff, 8'ha5);
        wrap_up();
    end
endmodule // asram_ctrl_tb
`default_nettype wire
